// >>> ldro_pkg.sv
// constants shared by the display link receiver and its per-pair lanes
// assumes a 25 MHz system clock and an 8-bit frame per pair per link clock
package ldro_pkg;

    localparam int CLK_NS     = 40;
    localparam int PAIRS      = 8;
    localparam int FRAME_BITS = 8;
    localparam int DATA_W     = 6;

    // register byte offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;

    // control register fields, reset value low as if the pins were left open
    localparam int CB_PWR_ON = 0;
    localparam int CB_BAL    = 1;
    localparam int CB_DESKEW = 2;
    localparam int CB_POL    = 3;
    localparam int CB_PLL    = 4;
    localparam int CTRL_W    = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

    // status register fields
    localparam int SB_MISSING   = 0;
    localparam int SB_DET_BAL   = 1;
    localparam int SB_MODE_BAL  = 2;
    localparam int SB_DESKEW_ON = 3;
    localparam int SB_SEL_LSB   = 8;

    // frame layout: bits 5:0 data, bit 6 inversion or legacy control, bit 7 control
    localparam int FB_INV = 6;
    localparam int FB_CTL = 7;
    localparam int CP_HS  = 0;
    localparam int CP_VS  = 1;
    localparam int CP_DE  = 2;
    localparam int CP_UA  = 3;
    localparam int CP_UB  = 4;

    // timing
    localparam int MISS_NS        = 1000;
    localparam int MISS_CYC       = MISS_NS / CLK_NS;
    localparam int BAL_HIGH_NS    = 160;
    localparam logic [3:0] BAL_HIGH_CYC = 4'(BAL_HIGH_NS / CLK_NS);
    localparam int STROBE_HIGH_NS = 160;
    localparam logic [2:0] STROBE_HIGH_CYC = 3'((STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] DESKEW_BLANK_MIN = 3'h4;

    // lane alignment choices and training pattern
    localparam logic [1:0] SEL_EARLY = 2'h0;
    localparam logic [1:0] SEL_NOM   = 2'h1;
    localparam logic [1:0] SEL_LATE  = 2'h2;
    localparam logic [DATA_W-1:0] DESKEW_PAT = 6'h07;

endpackage : ldro_pkg

// >>> ldro_lane.sv
// one serial pair: shift register and a one-sample early/late alignment pick
// assumes its bit input is already synchronised to i_clock
`timescale 1ns/1ps
module ldro_lane
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_bit,
    input  wire logic       i_enable,
    input  wire logic       i_train,
    output logic [7:0]      o_word,
    output logic [1:0]      o_sel
);

    logic [9:0] sh_q;
    logic [1:0] sel_q;
    logic [1:0] sel_d;
    wire        m_early = (sh_q[7:2] == ldro_pkg::DESKEW_PAT);
    wire        m_nom   = (sh_q[6:1] == ldro_pkg::DESKEW_PAT);
    wire        m_late  = (sh_q[5:0] == ldro_pkg::DESKEW_PAT);

    // window pick: nominal word is one sample behind the newest
    assign o_word = (sel_q == ldro_pkg::SEL_EARLY) ? sh_q[9:2] :
                    (sel_q == ldro_pkg::SEL_LATE)  ? sh_q[7:0] : sh_q[8:1];
    assign o_sel  = sel_q;

    // nominal wins a tie so a clean link never drifts off centre
    assign sel_d = !i_enable          ? ldro_pkg::SEL_NOM :
                   !i_train           ? sel_q :
                   m_nom              ? ldro_pkg::SEL_NOM :
                   m_early            ? ldro_pkg::SEL_EARLY :
                   m_late             ? ldro_pkg::SEL_LATE : sel_q;

    // shift every cycle, msb of the frame first
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            sh_q  <= 10'h000;
            sel_q <= ldro_pkg::SEL_NOM;
        end
        else
        begin
            sh_q  <= {sh_q[8:0], i_bit};
            sel_q <= sel_d;
        end
    end

    chk_lane_off_nominal: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_enable |=> (o_sel == ldro_pkg::SEL_NOM))
        else $error("lane kept a skew pick with deskew off");

endmodule : ldro_lane

// >>> ldro_receiver.sv
// display link receiver: pin sampling, frame capture, decode, parallel outputs
// assumes link pins are asynchronous and the Avalon master obeys waitrequest
`timescale 1ns/1ps
module ldro_receiver
#(
    parameter int MISS_CYC = ldro_pkg::MISS_CYC
)
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_serial_data_pos,
    input  wire logic [7:0]  i_serial_data_neg,
    input  wire logic        i_link_clock_pos,
    input  wire logic        i_link_clock_neg,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic [15:0]      o_red_out,
    output logic [15:0]      o_green_out,
    output logic [15:0]      o_blue_out,
    output logic             o_line_pulse,
    output logic             o_first_line_marker,
    output logic             o_pixel_valid,
    output logic             o_user_control_a,
    output logic             o_user_control_b,
    output logic             o_parallel_strobe_clock,
    output logic             o_clock_missing
);

    localparam int NP = ldro_pkg::PAIRS;

    if (MISS_CYC < 2 || MISS_CYC > 31)
    begin : g_bad_miss
        $error("MISS_CYC must lie in 2..31");
    end

    // two-stage synchroniser for all link pins
    logic [2*NP+1:0] meta_q;
    logic [2*NP+1:0] sync_q;
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= {i_link_clock_pos, i_link_clock_neg,
                       i_serial_data_pos, i_serial_data_neg};
            sync_q <= meta_q;
        end
    end

    // fail-safe inputs sit both high, which decodes as a low bit and no clock
    wire [NP-1:0] link_bits = sync_q[2*NP-1:NP] & ~sync_q[NP-1:0];
    wire          link_clk  = sync_q[2*NP+1] & ~sync_q[2*NP];

    logic              clk_prev_q;
    logic [4:0]        miss_cnt_q;
    logic              miss_q;
    logic [3:0]        hi_cnt_q;
    logic              det_bal_q;
    logic              cap_q;
    logic [2:0]        blank_cnt_q;
    logic [ldro_pkg::CTRL_W-1:0] ctrl_q;
    wire               link_edge = link_clk & ~clk_prev_q;

    // control register fields
    wire pwr_on     = ctrl_q[ldro_pkg::CB_PWR_ON];
    wire bal_sel    = ctrl_q[ldro_pkg::CB_BAL];
    wire deskew_sel = ctrl_q[ldro_pkg::CB_DESKEW];
    wire pol_sel    = ctrl_q[ldro_pkg::CB_POL];
    wire mode_bal   = bal_sel & det_bal_q;
    wire deskew_on  = deskew_sel & mode_bal;

    // clock watchdog and high-phase measure
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            clk_prev_q <= 1'b0;
            miss_cnt_q <= 5'h00;
            miss_q     <= 1'b1;
            hi_cnt_q   <= 4'h0;
            det_bal_q  <= 1'b0;
            cap_q      <= 1'b0;
        end
        else
        begin
            clk_prev_q <= link_clk;
            cap_q      <= link_edge & ~miss_q;
            if (link_edge)
            begin
                miss_cnt_q <= 5'h00;
                miss_q     <= 1'b0;
                hi_cnt_q   <= 4'h1;
                if (!miss_q)
                    det_bal_q <= (hi_cnt_q <= ldro_pkg::BAL_HIGH_CYC);
            end
            else
            begin
                if (miss_cnt_q == 5'(MISS_CYC - 1))
                    miss_q <= 1'b1;
                else
                    miss_cnt_q <= miss_cnt_q + 5'h01;
                if (link_clk && hi_cnt_q != 4'hF)
                    hi_cnt_q <= hi_cnt_q + 4'h1;
            end
        end
    end

    // lanes and decode
    logic [7:0]      word [NP];
    logic [2*NP-1:0] sel_flat;
    logic [47:0]     colour;
    wire             train;
    for (genvar p = 0; p < NP; p++)
    begin : g_lane
        ldro_lane u_lane
        (
            .i_clock  (i_clock),
            .i_rst_n  (i_rst_n),
            .i_bit    (link_bits[p]),
            .i_enable (deskew_on),
            .i_train  (train),
            .o_word   (word[p]),
            .o_sel    (sel_flat[2*p +: 2])
        );
        // balanced frames may arrive inverted, flagged in bit 6
        assign colour[ldro_pkg::DATA_W*p +: ldro_pkg::DATA_W] =
            word[p][ldro_pkg::DATA_W-1:0]
            ^ {ldro_pkg::DATA_W{mode_bal & word[p][ldro_pkg::FB_INV]}};
    end

    // control bits sit in bit 7 when balanced, bit 6 when legacy
    wire [4:0] ctl_bal = {word[ldro_pkg::CP_UB][ldro_pkg::FB_CTL],
                          word[ldro_pkg::CP_UA][ldro_pkg::FB_CTL],
                          word[ldro_pkg::CP_DE][ldro_pkg::FB_CTL],
                          word[ldro_pkg::CP_VS][ldro_pkg::FB_CTL],
                          word[ldro_pkg::CP_HS][ldro_pkg::FB_CTL]};
    wire [4:0] ctl_leg = {2'b00,
                          word[ldro_pkg::CP_DE][ldro_pkg::FB_INV],
                          word[ldro_pkg::CP_VS][ldro_pkg::FB_INV],
                          word[ldro_pkg::CP_HS][ldro_pkg::FB_INV]};
    wire [4:0] ctl        = mode_bal ? ctl_bal : ctl_leg;
    wire       pix_active = pol_sel ? ctl[ldro_pkg::CP_DE] : ~ctl[ldro_pkg::CP_DE];

    // training only once enough blanking frames have gone by
    assign train = cap_q & deskew_on & ~pix_active
                   & (blank_cnt_q >= ldro_pkg::DESKEW_BLANK_MIN - 3'h1);

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n || !deskew_on)
            blank_cnt_q <= 3'h0;
        else if (cap_q)
            blank_cnt_q <= pix_active ? 3'h0 :
                           (blank_cnt_q == 3'h7) ? blank_cnt_q : blank_cnt_q + 3'h1;
    end

    // parallel outputs: load on capture, strobe falls mid-period
    logic [2:0] strobe_cnt_q;
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n || !pwr_on)
        begin
            {o_blue_out, o_green_out, o_red_out} <= 48'h0;
            {o_user_control_b, o_user_control_a, o_pixel_valid,
             o_first_line_marker, o_line_pulse} <= 5'h00;
            o_parallel_strobe_clock <= 1'b1;
            strobe_cnt_q            <= 3'h0;
        end
        else if (cap_q)
        begin
            {o_blue_out, o_green_out, o_red_out} <= colour;
            o_line_pulse            <= ctl[ldro_pkg::CP_HS];
            o_first_line_marker     <= ctl[ldro_pkg::CP_VS];
            o_pixel_valid           <= pix_active;
            o_user_control_a        <= ctl[ldro_pkg::CP_UA];
            o_user_control_b        <= ctl[ldro_pkg::CP_UB];
            o_parallel_strobe_clock <= 1'b1;
            strobe_cnt_q            <= 3'h0;
        end
        else if (o_parallel_strobe_clock)
        begin
            // without a capture the strobe falls after STROBE_HIGH_CYC cycles high, then stays low, and data holds
            if (strobe_cnt_q == ldro_pkg::STROBE_HIGH_CYC - 3'h1)
                o_parallel_strobe_clock <= 1'b0;
            else
                strobe_cnt_q <= strobe_cnt_q + 3'h1;
        end
    end

    assign o_clock_missing = miss_q;

    // Avalon slave: one wait state, read data registered
    logic ack_q;
    logic [31:0] status_w;
    wire req      = i_avs_read | i_avs_write;
    wire hit_ctrl = (i_avs_address == ldro_pkg::OFS_CTRL);
    wire hit_stat = (i_avs_address == ldro_pkg::OFS_STATUS);
    wire wr_ctrl  = i_avs_write & ack_q & hit_ctrl & i_avs_byteenable[0];
    assign o_avs_waitrequest = req & ~ack_q;

    always_comb
    begin
        status_w                               = 32'h0;
        status_w[ldro_pkg::SB_MISSING]         = miss_q;
        status_w[ldro_pkg::SB_DET_BAL]         = det_bal_q;
        status_w[ldro_pkg::SB_MODE_BAL]        = mode_bal;
        status_w[ldro_pkg::SB_DESKEW_ON]       = deskew_on;
        status_w[ldro_pkg::SB_SEL_LSB +: 2*NP] = sel_flat;
    end

    wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl_q} :
                         hit_stat ? status_w : 32'h0;

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            ack_q          <= 1'b0;
            o_avs_readdata <= 32'h0;
            ctrl_q         <= ldro_pkg::CTRL_RST;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            if (i_avs_read && !ack_q)
                o_avs_readdata <= rd_mux;
            if (wr_ctrl)
                ctrl_q <= i_avs_writedata[ldro_pkg::CTRL_W-1:0];
        end
    end

    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    chk_pd_forces_low: assert property (
        !pwr_on |=> (o_red_out == 16'h0 && o_green_out == 16'h0
                     && o_blue_out == 16'h0 && o_parallel_strobe_clock))
        else $error("power-down did not clear data or raise strobe");

    chk_missing_rises: assert property (
        (miss_cnt_q == 5'(MISS_CYC - 1) && !link_edge) |=> o_clock_missing)
        else $error("missing flag not raised after timeout");

    chk_clock_present: assert property (
        link_edge |=> !o_clock_missing [*2])
        else $error("missing flag high right after a link edge");

    chk_hold_missing: assert property (
        (o_clock_missing && !cap_q) ##1 pwr_on |->
        ($stable(o_red_out) && $stable(o_pixel_valid) && $stable(o_user_control_a)))
        else $error("outputs moved with link clock absent");

    chk_legacy_no_user: assert property (
        (cap_q && pwr_on && !bal_sel) |=> (!o_user_control_a && !o_user_control_b))
        else $error("user controls driven in legacy format");

    chk_auto_detect: assert property (
        (link_edge && !miss_q && hi_cnt_q > ldro_pkg::BAL_HIGH_CYC) |=> !det_bal_q)
        else $error("long clock high phase taken as balanced");

    chk_deskew_needs_bal: assert property (
        !bal_sel ##1 !bal_sel |-> (sel_flat == {NP{ldro_pkg::SEL_NOM}}))
        else $error("skew applied with balance mode off");

    // power-down clears data at once, so only a powered fall is judged
    chk_strobe_stable: assert property (
        ($fell(o_parallel_strobe_clock) && pwr_on) |->
        ($stable(o_red_out) && $stable(o_blue_out) && $stable(o_pixel_valid))
        ##1 ($stable(o_red_out) && $stable(o_pixel_valid)))
        else $error("data changed around strobe falling edge");

    chk_valid_polarity: assert property (
        (cap_q && pwr_on && pol_sel) |=> (o_pixel_valid == $past(ctl[ldro_pkg::CP_DE])))
        else $error("valid does not follow enable with polarity high");

    cov_balanced_capture: cover property (cap_q && mode_bal && pix_active);
    cov_deskew_train:     cover property (train);
    cov_clock_lost:       cover property ($rose(o_clock_missing));
    cov_power_down:       cover property ($fell(pwr_on));

endmodule : ldro_receiver

// >>> ldro_tx_model.sv
// behavioural link transmitter: eight data pairs plus a forwarded link clock
// assumes 8 system cycles per link period and bench-held frame contents
`timescale 1ns/1ps
module ldro_tx_model
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_run,
    input  wire logic        i_short_high,
    input  wire logic [63:0] i_frame,
    input  wire logic        i_skew,
    output logic [7:0]       o_data_pos,
    output logic [7:0]       o_data_neg,
    output logic             o_clk_pos,
    output logic             o_clk_neg
);
    logic [2:0] phase_q;
    logic [7:0] bits_d;
    logic [2:0] high_len;
    logic       lag_q;
    logic [7:0] lane_bits;

    // bit 7 of every pair leaves first, together with the clock rise
    always_comb
    begin
        for (int p = 0; p < 8; p++)
            bits_d[p] = i_frame[8 * p + 7 - int'(phase_q)];
    end
    // short high phase marks the balanced format, long high the legacy one
    assign high_len = i_short_high ? 3'h4 : 3'h5;
    // pair 0 may trail the others by one sample so the receiver has skew to remove
    assign lane_bits = {bits_d[7:1], i_skew ? lag_q : bits_d[0]};

    // between frames the clock stands low and released data lines keep toggling
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            phase_q    <= 3'h0;
            lag_q      <= 1'b0;
            o_clk_pos  <= 1'b0;
            o_clk_neg  <= 1'b1;
            o_data_pos <= 8'h00;
            o_data_neg <= 8'hFF;
        end
        else if (!i_run)
        begin
            phase_q    <= 3'h0;
            o_clk_pos  <= 1'b0;
            o_clk_neg  <= 1'b1;
            o_data_pos <= ~o_data_pos;
            o_data_neg <= ~o_data_neg;
        end
        else
        begin
            phase_q    <= phase_q + 3'h1;
            o_clk_pos  <= phase_q < high_len;
            o_clk_neg  <= !(phase_q < high_len);
            lag_q      <= bits_d[0];
            o_data_pos <= lane_bits;
            o_data_neg <= ~lane_bits;
        end
    end
endmodule : ldro_tx_model

// >>> ldro_receiver_bench.sv
// self-checking bench for the display link receiver
// assumes the transmitter model above and the register map of the package
`timescale 1ns/1ps
module ldro_receiver_bench;
    logic        i_clock, i_rst_n, run, short_high, rd, wr, wait_req, strobe, missing;
    logic        hs, vs, de, ua, ub, cp, cn, skew;
    logic [63:0] frame;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, avs_rd;
    logic [7:0]  dp, dn;
    logic [15:0] red, green, blue;
    logic [52:0] got;
    int          error_cnt, tests_run, cycles;

    assign got = {ub, ua, de, vs, hs, blue, green, red};

    ldro_tx_model tx (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_run(run),
        .i_short_high(short_high), .i_frame(frame), .i_skew(skew),
        .o_data_pos(dp), .o_data_neg(dn),
        .o_clk_pos(cp), .o_clk_neg(cn));

    // short missing-clock count keeps the stop scenario brief
    ldro_receiver #(.MISS_CYC(10)) DUT (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_serial_data_pos(dp), .i_serial_data_neg(dn), .i_link_clock_pos(cp),
        .i_link_clock_neg(cn), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(avs_rd),
        .o_avs_waitrequest(wait_req), .o_red_out(red), .o_green_out(green),
        .o_blue_out(blue), .o_line_pulse(hs), .o_first_line_marker(vs),
        .o_pixel_valid(de), .o_user_control_a(ua), .o_user_control_b(ub),
        .o_parallel_strobe_clock(strobe), .o_clock_missing(missing));

    initial
    begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // a hang counts as a mismatch
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // one Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        wr    <= w;
        rd    <= !w;
        addr  <= a;
        wdata <= d;
        do
        begin
            @(posedge i_clock);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        rdata = avs_rd;
        wr <= 1'b0;
        rd <= 1'b0;
        check("bus answer", 64'(n < 50), 64'h1);
    endtask : bus

    // expected outputs from one frame; pair p carries byte p of the frame
    function automatic logic [63:0] exp_out(input logic [63:0] f, input logic balance_mode_select, pol);
        logic [47:0] c;
        logic [4:0]  k;
        for (int p = 0; p < 8; p++)
            c[6 * p +: 6] = (balance_mode_select && f[8 * p + 6]) ? ~f[8 * p +: 6] : f[8 * p +: 6];
        k = balance_mode_select ? {f[39], f[31], f[23], f[15], f[7]} : {2'b00, f[22], f[14], f[6]};
        k[2] = pol ? k[2] : ~k[2];
        return {11'h000, k[4:3], k[2], k[1], k[0], c};
    endfunction : exp_out

    // counts strobe falls seen at rising edges; returns in the first low cycle
    task automatic wait_falls(input int n);
        int   k, c;
        logic p;
        k = 0;
        c = 0;
        p = strobe;
        while (k < n && c < 200)
        begin
            @(posedge i_clock);
            c++;
            if (p === 1'b1 && strobe === 1'b0)
                k++;
            p = strobe;
        end
        check("strobe falls", 64'(k), 64'(n));
    endtask : wait_falls

    // outputs are judged at the strobe fall, as downstream logic takes them
    task automatic show(input logic [63:0] f, input logic shrt, balance_mode_select, pol);
        frame      <= f;
        short_high <= shrt;
        wait_falls(3);
        check("pixel outputs", 64'(got), exp_out(f, balance_mode_select, pol));
    endtask : show

    task automatic t_reset;
        check("reset outputs", 64'({strobe, missing, got}), 64'({2'b11, 53'h0}));
        bus(1'b0, 4'h0, 32'h0);
        check("ctrl reset", 64'(rdata), 64'h0);
        bus(1'b1, 4'h8, 32'h1F);
        bus(1'b0, 4'h8, 32'h0);
        check("unmapped read", 64'(rdata), 64'h0);
        bus(1'b0, 4'h0, 32'h0);
        check("ctrl after unmapped", 64'(rdata), 64'h0);
    endtask : t_reset

    task automatic t_power_down;
        frame <= 64'hFFFF_FFFF_FFFF_FFFF;
        run   <= 1'b1;
        bus(1'b1, 4'h0, 32'h10);
        repeat (40) @(posedge i_clock);
        check("missing low", 64'(missing), 64'h0);
        check("power down", 64'({strobe, got}), 64'({1'b1, 53'h0}));
    endtask : t_power_down

    task automatic t_modes;
        bus(1'b1, 4'h0, 32'h19);
        show(64'h5A3C_C3A5_7E81_42BD, 1'b0, 1'b0, 1'b1);
        show(64'h0F1E_2D3C_4B5A_6978, 1'b1, 1'b0, 1'b1);
        bus(1'b1, 4'h0, 32'h1B);
        show(64'h5A3C_C3A5_7E81_42BD, 1'b1, 1'b1, 1'b1);
        show(64'h5A3C_C3A5_7E81_42BD, 1'b0, 1'b0, 1'b1);
        bus(1'b1, 4'h0, 32'h13);
        show(64'h1122_33C4_D596_A7B8, 1'b1, 1'b1, 1'b0);
        bus(1'b1, 4'h0, 32'h1B);
        show(64'h1122_33C4_D596_A7B8, 1'b1, 1'b1, 1'b1);
        // power-down while live data stands must clear it
        bus(1'b1, 4'h0, 32'h1A);
        repeat (2) @(posedge i_clock);
        check("power down busy", 64'({strobe, got}), 64'({1'b1, 53'h0}));
    endtask : t_modes

    // pair 0 trails one sample; blanking frames with polarity high carry the pattern
    task automatic t_deskew;
        bus(1'b1, 4'h0, 32'h1F);
        frame <= 64'h0707_0707_0707_0707;
        skew  <= 1'b1;
        wait_falls(8);
        check("deskewed pixels", 64'(got), exp_out(64'h0707_0707_0707_0707, 1'b1, 1'b1));
        bus(1'b0, 4'h4, 32'h0);
        check("deskew on", 64'(rdata[3]), 64'h1);
        check("pair picks", 64'(rdata[23:8]), 64'h5556);
        bus(1'b1, 4'h0, 32'h13);
        bus(1'b0, 4'h4, 32'h0);
        check("deskew off", 64'(rdata[3]), 64'h0);
        check("picks back nominal", 64'(rdata[23:8]), 64'h5555);
        bus(1'b1, 4'h0, 32'h1D);
        wait_falls(3);
        bus(1'b0, 4'h4, 32'h0);
        check("deskew needs balance", 64'(rdata[3]), 64'h0);
        check("no pick without balance", 64'(rdata[23:8]), 64'h5555);
        skew <= 1'b0;
    endtask : t_deskew

    task automatic t_stop;
        int n;
        bus(1'b1, 4'h0, 32'h19);
        show(64'hC3A5_5A3C_8142_BD7E, 1'b0, 1'b0, 1'b1);
        run <= 1'b0;
        n = 0;
        while (missing !== 1'b1 && n < 40)
        begin
            @(posedge i_clock);
            n++;
        end
        check("missing high", 64'(missing), 64'h1);
        check("held outputs", 64'(got), exp_out(64'hC3A5_5A3C_8142_BD7E, 1'b0, 1'b1));
    endtask : t_stop

    initial
    begin
        i_rst_n    = 1'b0;
        run        = 1'b0;
        short_high = 1'b0;
        skew       = 1'b0;
        frame      = 64'h0;
        rd         = 1'b0;
        wr         = 1'b0;
        addr       = 4'h0;
        wdata      = 32'h0;
        error_cnt  = 0;
        tests_run  = 0;
        cycles     = 0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_reset();
        t_power_down();
        t_modes();
        t_deskew();
        t_stop();
        end_of_test();
    end
endmodule : ldro_receiver_bench
